/* File: vsp_pattern.sv */
`timescale 1ns/1ps
module vsp_pattern
  import vsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       restart,
  input  wire logic       word_tick,
  input  wire logic [3:0] code,
  output logic      [9:0] word
);
  logic [11:0] pix_reg;
  logic [11:0] pix_next;
  logic [2:0]  bar_reg;
  logic [2:0]  bar_next;
  logic [9:0]  word_next;
  logic [11:0] line_len;
  logic [9:0]  bar_luma;
  logic [9:0]  bar_chroma;
  vsp_pat_e    pat;

  always_comb begin
    pat = vsp_pat_e'(code[1:0]);
    unique case ({code[CODE_RASTER_BIT], code[CODE_STD_BIT]})
      2'b00: line_len = LINE_NTSC_4X3;
      2'b01: line_len = LINE_PAL_4X3;
      2'b10: line_len = LINE_NTSC_16X9;
      2'b11: line_len = LINE_PAL_16X9;
    endcase
    // Bars step down in luma; no edge shaping between bars
    bar_luma   = 10'h3AC - {1'b0, bar_reg, 6'h00} - {3'h0, bar_reg, 4'h0};
    bar_chroma = bar_reg[0] ? 10'h2C0 : 10'h140;
    pix_next   = pix_reg;
    bar_next   = bar_reg;
    word_next  = word;
    if (restart) begin
      pix_next  = 12'h000;
      bar_next  = 3'h0;
      word_next = BLACK_C;
    end else if (word_tick) begin
      pix_next = (pix_reg == line_len - 12'h001) ? 12'h000 : pix_reg + 12'h001;
      if (pix_next == 12'h000) begin
        bar_next = 3'h0;
      end else if (pix_next[8:0] == 9'h000 && line_len[11:3] != 9'h000) begin
        bar_next = bar_reg + 3'h1;
      end
      unique case (pat)
        VSP_PAT_BLACK: word_next = pix_reg[0] ? BLACK_Y : BLACK_C;
        VSP_PAT_PLL:   word_next = pix_reg[0] ? PLL_Y : PLL_C;
        VSP_PAT_EQ:    word_next = pix_reg[0] ? EQ_Y : EQ_C;
        VSP_PAT_BARS:  word_next = pix_reg[0] ? bar_luma : bar_chroma;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pix_reg <= 12'h000;
      bar_reg <= 3'h0;
      word    <= BLACK_C;
    end else begin
      pix_reg <= pix_next;
      bar_reg <= bar_next;
      word    <= word_next;
    end
  end
endmodule

/* File: vsp_pkg.sv */
package vsp_pkg;
  localparam int          CLK_MHZ          = 100;
  localparam int          WORD_BITS        = 10;
  localparam int          CODE_BITS        = 4;
  localparam logic [3:0]  BITS_LAST        = 4'h9;
  // Field intervals in microseconds
  localparam int          NTSC_FIELD_US    = 16683;
  localparam int          PAL_FIELD_US     = 20000;
  localparam int          NTSC_FIELD_CYC   = NTSC_FIELD_US * CLK_MHZ;
  localparam int          PAL_FIELD_CYC    = PAL_FIELD_US * CLK_MHZ;
  localparam int          SELF_FIELDS      = 2;
  // Pattern code fields
  localparam int          CODE_RASTER_BIT  = 3;
  localparam int          CODE_STD_BIT     = 2;
  localparam logic [3:0]  CODE_NTSC_BARS   = 4'h3;
  localparam logic [3:0]  CODE_PAL_PLL     = 4'h5;
  typedef enum logic [1:0] {
    VSP_PAT_BLACK = 2'b00,
    VSP_PAT_PLL   = 2'b01,
    VSP_PAT_EQ    = 2'b10,
    VSP_PAT_BARS  = 2'b11
  } vsp_pat_e;
  // Words per line per raster and standard
  localparam logic [11:0] LINE_NTSC_4X3    = 12'h6B4;
  localparam logic [11:0] LINE_PAL_4X3     = 12'h6C0;
  localparam logic [11:0] LINE_NTSC_16X9   = 12'h8F0;
  localparam logic [11:0] LINE_PAL_16X9    = 12'h900;
  // Pattern words, chroma then luma
  localparam logic [9:0]  BLACK_C          = 10'h200;
  localparam logic [9:0]  BLACK_Y          = 10'h040;
  localparam logic [9:0]  PLL_C            = 10'h300;
  localparam logic [9:0]  PLL_Y            = 10'h198;
  localparam logic [9:0]  EQ_C             = 10'h200;
  localparam logic [9:0]  EQ_Y             = 10'h110;
  localparam logic [9:0]  TRS_ONES         = 10'h3FF;
  localparam logic [9:0]  TRS_ZERO         = 10'h000;
  localparam logic [9:0]  CLIP_LOW_MAX     = 10'h003;
  localparam logic [9:0]  CLIP_HIGH_MIN    = 10'h3FC;
  // Register map
  localparam logic [3:0]  REG_CTRL         = 4'h0;
  localparam logic [3:0]  REG_STATUS       = 4'h4;
  localparam logic [3:0]  REG_IRQ_STAT     = 4'h8;
  localparam logic [3:0]  REG_IRQ_MASK     = 4'hC;
  localparam logic [1:0]  CTRL_RESET       = 2'h1;
  localparam logic [3:0]  MASK_RESET       = 4'h0;
  localparam int          IRQ_LOCK         = 0;
  localparam int          IRQ_PASS         = 1;
  localparam int          IRQ_FAIL         = 2;
  localparam int          IRQ_TRS          = 3;
endpackage

/* File: vsp_src_model.sv */
`timescale 1ns/1ps
module vsp_src_model
  import vsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [9:0] cmd_data,
  input  wire logic       cmd_test,
  input  wire logic       cmd_en,
  input  wire logic       cmd_lock,
  input  wire logic       cmd_sync_n,
  input  wire logic       cmd_tie,
  input  wire logic       lock_in,
  input  wire logic       serial_true,
  input  wire logic       serial_comp,
  output logic      [9:0] par_data,
  output logic            pattern_gen_enable,
  output logic            sync_detect_enable_n,
  output logic            pll_locked,
  output logic      [9:0] rx_word,
  output logic            pair_bad
);
  logic en_reg;

  // Strapping mode: enable follows lock directly
  assign pattern_gen_enable = cmd_tie ? lock_in : en_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Pull-downs: nothing driven reads as zero
      par_data             <= 10'h000;
      en_reg               <= 1'b0;
      sync_detect_enable_n <= 1'b0;
      pll_locked           <= 1'b0;
      rx_word              <= 10'h000;
      pair_bad             <= 1'b0;
    end else begin
      par_data             <= cmd_test ? {6'h00, cmd_data[3:0]} : cmd_data;
      // Enable only once lock is seen
      en_reg               <= cmd_en & lock_in;
      sync_detect_enable_n <= cmd_sync_n;
      pll_locked           <= cmd_lock;
      // Bits arrive LSB first
      rx_word              <= {serial_true, rx_word[9:1]};
      if (serial_comp !== ~serial_true) begin
        pair_bad <= 1'b1;
      end
    end
  end
endmodule

/* File: vsp_sync2.sv */
`timescale 1ns/1ps
module vsp_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end
endmodule

/* File: vsp_top.sv */
// Overview of operation
// - Code bits: raster, standard, two-bit pattern
// - Code comes from lowest four data inputs
// - Self-check uses NTSC bars or PAL pathological
// - Undriven inputs read as zero
// - High enable starts pattern, low is normal
// - Lock output follows oscillator lock
// - Low sync input enables timing detection
// - Serial pair is true and complement
// - Pass rises two fields later unless error
// - Enable low ends pattern and self-check
`timescale 1ns/1ps
module vsp_top
  import vsp_pkg::*;
#(
  parameter int NTSC_CYC = SELF_FIELDS * NTSC_FIELD_CYC,
  parameter int PAL_CYC  = SELF_FIELDS * PAL_FIELD_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [9:0] par_data,
  input  wire logic       pattern_gen_enable,
  input  wire logic       sync_detect_enable_n,
  input  wire logic       pll_locked,
  input  wire logic [3:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  output logic      [31:0] bus_rdata,
  output logic            lock_detect,
  output logic            self_check_pass,
  output logic            serial_out_pair_true,
  output logic            serial_out_pair_comp,
  output logic            irq
);
  logic [11:0] pin_s;
  logic [9:0]  data_s;
  logic        en_s;
  logic        sync_n_s;
  logic        lock_s;
  logic [9:0]  pat_word;

  // Pins are undriven-safe: pull-down means zero after reset
  vsp_sync2 #(.WIDTH(12)) u_sync_pins (
    .clk (clk),
    .rst (rst),
    .d   ({pattern_gen_enable, sync_detect_enable_n, par_data}),
    .q   (pin_s)
  );
  vsp_sync2 #(.WIDTH(1)) u_sync_lock (
    .clk (clk),
    .rst (rst),
    .d   (pll_locked),
    .q   (lock_s)
  );
  assign data_s   = pin_s[9:0];
  assign sync_n_s = pin_s[10];
  assign en_s     = pin_s[11];

  logic [3:0]  bit_reg, bit_next;
  logic        active_reg, active_next;
  logic        en_d_reg, en_d_next;
  logic [3:0]  code_reg, code_next;
  logic        run_reg, run_next;
  logic [31:0] cnt_reg, cnt_next;
  logic        err_reg, err_next;
  logic        pass_next;
  logic [9:0]  shift_reg, shift_next;
  logic [9:0]  sent_reg, sent_next;
  logic [9:0]  prev_reg, prev_next;
  logic [9:0]  cap_reg, cap_next;
  logic        chk_ok_reg, chk_ok_next;
  logic        valid_reg, valid_next;
  logic [9:0]  h1_reg, h1_next, h2_reg, h2_next;
  logic        trs_hit;
  logic        true_next, comp_next, lock_next;
  logic [31:0] done_cyc;
  logic [9:0]  clip_word;
  logic        tick, restart;

  assign tick    = (bit_reg == BITS_LAST);
  assign restart = en_s && !en_d_reg;

  always_comb begin
    bit_next    = tick ? 4'h0 : bit_reg + 4'h1;
    en_d_next   = en_s;
    active_next = en_s;
    code_next   = restart ? data_s[3:0] : code_reg;
    done_cyc    = code_reg[CODE_STD_BIT] ? PAL_CYC : NTSC_CYC;
    run_next    = run_reg;
    cnt_next    = cnt_reg;
    err_next    = err_reg;
    if (!en_s) begin
      run_next = 1'b0;
      err_next = 1'b0;
      cnt_next = 32'h0;
    end else if (restart) begin
      run_next = (data_s[3:0] == CODE_NTSC_BARS) || (data_s[3:0] == CODE_PAL_PLL);
      cnt_next = 32'h0;
      err_next = 1'b0;
    end else if (run_reg) begin
      if (cnt_reg != done_cyc) begin
        cnt_next = cnt_reg + 32'h1;
      end
      if (!chk_ok_reg || (serial_out_pair_comp == serial_out_pair_true)) begin
        err_next = 1'b1;
      end
    end
    pass_next = run_reg && (cnt_reg == done_cyc) && !err_reg && !err_next;
  end

  // Sync clipping applies only with detection enabled
  always_comb begin
    clip_word = data_s;
    if (!sync_n_s) begin
      if (data_s <= CLIP_LOW_MAX) begin
        clip_word = TRS_ZERO;
      end else if (data_s >= CLIP_HIGH_MIN) begin
        clip_word = TRS_ONES;
      end
    end
    h1_next = tick ? clip_word : h1_reg;
    h2_next = tick ? h1_reg : h2_reg;
    trs_hit = tick && !sync_n_s && (h2_reg == TRS_ONES) && (h1_reg == TRS_ZERO)
              && (clip_word == TRS_ZERO);
  end

  // Loopback check of what actually left the shifter
  always_comb begin
    shift_next  = {1'b0, shift_reg[9:1]};
    sent_next   = sent_reg;
    prev_next   = prev_reg;
    valid_next  = valid_reg;
    cap_next    = {shift_reg[0], cap_reg[9:1]};
    chk_ok_next = chk_ok_reg;
    if (tick) begin
      shift_next = active_reg ? pat_word : clip_word;
      sent_next  = shift_next;
      prev_next  = sent_reg;
      valid_next = 1'b1;
    end
    if (bit_reg == 4'h0 && valid_reg) begin
      chk_ok_next = (cap_reg == prev_reg);
    end
    true_next = lock_s && shift_reg[0];
    comp_next = !true_next;
    lock_next = lock_s;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_reg              <= 4'h0;
      en_d_reg             <= 1'b0;
      active_reg           <= 1'b0;
      code_reg             <= 4'h0;
      run_reg              <= 1'b0;
      cnt_reg              <= 32'h0;
      err_reg              <= 1'b0;
      self_check_pass      <= 1'b0;
      shift_reg            <= 10'h000;
      sent_reg             <= 10'h000;
      prev_reg             <= 10'h000;
      cap_reg              <= 10'h000;
      chk_ok_reg           <= 1'b1;
      valid_reg            <= 1'b0;
      h1_reg               <= 10'h000;
      h2_reg               <= 10'h000;
      serial_out_pair_true <= 1'b0;
      serial_out_pair_comp <= 1'b1;
      lock_detect          <= 1'b0;
    end else begin
      bit_reg              <= bit_next;
      en_d_reg             <= en_d_next;
      active_reg           <= active_next;
      code_reg             <= code_next;
      run_reg              <= run_next;
      cnt_reg              <= cnt_next;
      err_reg              <= err_next;
      self_check_pass      <= pass_next;
      shift_reg            <= shift_next;
      sent_reg             <= sent_next;
      prev_reg             <= prev_next;
      cap_reg              <= cap_next;
      chk_ok_reg           <= chk_ok_next;
      valid_reg            <= valid_next;
      h1_reg               <= h1_next;
      h2_reg               <= h2_next;
      serial_out_pair_true <= true_next;
      serial_out_pair_comp <= comp_next;
      lock_detect          <= lock_next;
    end
  end

  vsp_pattern u_pattern (
    .clk       (clk),
    .rst       (rst),
    .restart   (restart),
    .word_tick (tick),
    .code      (code_reg),
    .word      (pat_word)
  );

  // Register file and interrupts
  logic [1:0]  ctrl_reg, ctrl_next;
  logic [3:0]  ist_reg, ist_next;
  logic [3:0]  mask_reg, mask_next;
  logic [3:0]  ev;
  logic [31:0] rdata_next;
  logic        irq_next;
  logic        lock_d_reg, lock_d_next;
  logic        pass_d_reg, pass_d_next;
  logic        err_d_reg, err_d_next;

  always_comb begin
    lock_d_next    = lock_s;
    pass_d_next    = pass_next;
    err_d_next     = err_next;
    ev             = 4'h0;
    ev[IRQ_LOCK]   = lock_s != lock_d_reg;
    ev[IRQ_PASS]   = pass_next && !pass_d_reg;
    ev[IRQ_FAIL]   = err_next && !err_d_reg;
    ev[IRQ_TRS]    = trs_hit && ctrl_reg[0];
    ctrl_next      = ctrl_reg;
    mask_next      = mask_reg;
    ist_next       = ist_reg;
    if (bus_wr && bus_addr == REG_CTRL) begin
      ctrl_next = bus_wdata[1:0];
    end
    if (bus_wr && bus_addr == REG_IRQ_MASK) begin
      mask_next = bus_wdata[3:0];
    end
    if (bus_wr && bus_addr == REG_IRQ_STAT) begin
      ist_next = ist_reg & ~bus_wdata[3:0];
    end
    // Set wins over a clear in the same cycle
    ist_next   = ist_next | ev;
    irq_next   = |(ist_next & mask_next);
    rdata_next = 32'h0;
    if (bus_rd) begin
      unique case (bus_addr)
        REG_CTRL:     rdata_next = {30'h0, ctrl_reg};
        REG_STATUS:   rdata_next = {20'h0, code_reg, 2'h0, err_reg, self_check_pass,
                                    run_reg, active_reg, sync_n_s, lock_s};
        REG_IRQ_STAT: rdata_next = {28'h0, ist_reg};
        REG_IRQ_MASK: rdata_next = {28'h0, mask_reg};
        default:      rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg   <= CTRL_RESET;
      ist_reg    <= 4'h0;
      mask_reg   <= MASK_RESET;
      irq        <= 1'b0;
      bus_rdata  <= 32'h0;
      lock_d_reg <= 1'b0;
      pass_d_reg <= 1'b0;
      err_d_reg  <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      ist_reg    <= ist_next;
      mask_reg   <= mask_next;
      irq        <= irq_next;
      bus_rdata  <= rdata_next;
      lock_d_reg <= lock_d_next;
      pass_d_reg <= pass_d_next;
      err_d_reg  <= err_d_next;
    end
  end

  property p_lock_follow;
    @(posedge clk) disable iff (rst) 1'b1 |=> lock_detect == $past(lock_s);
  endproperty
  a_lock_follow: assert property (p_lock_follow) else $error("lock output mismatch");

  property p_pair;
    @(posedge clk) disable iff (rst) serial_out_pair_comp == !serial_out_pair_true;
  endproperty
  a_pair: assert property (p_pair) else $error("serial pair not complementary");

  property p_self_code;
    @(posedge clk) disable iff (rst)
      run_reg |-> (code_reg == CODE_NTSC_BARS || code_reg == CODE_PAL_PLL);
  endproperty
  a_self_code: assert property (p_self_code) else $error("self-check with bad code");

  property p_end;
    @(posedge clk) disable iff (rst) !en_s |=> !run_reg && !active_reg ##1 !self_check_pass;
  endproperty
  a_end: assert property (p_end) else $error("enable low did not end test");

  property p_fail_low;
    @(posedge clk) disable iff (rst) err_reg |-> !self_check_pass;
  endproperty
  a_fail_low: assert property (p_fail_low) else $error("pass high with error");

  property p_pass_time;
    @(posedge clk) disable iff (rst)
      $rose(self_check_pass) |-> $past(cnt_reg) == done_cyc && $past(run_reg);
  endproperty
  a_pass_time: assert property (p_pass_time) else $error("pass rose early");

  property p_normal;
    @(posedge clk) disable iff (rst) tick && !active_reg |=> shift_reg == $past(clip_word);
  endproperty
  a_normal: assert property (p_normal) else $error("normal word not loaded");

  property p_pattern;
    @(posedge clk) disable iff (rst) tick && active_reg |=> shift_reg == $past(pat_word);
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern word not loaded");

  property p_code;
    @(posedge clk) disable iff (rst) restart |=> code_reg == $past(data_s[3:0]);
  endproperty
  a_code: assert property (p_code) else $error("code not taken from low bits");

  property p_sync_off;
    @(posedge clk) disable iff (rst) sync_n_s |-> !trs_hit;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("timing detect while disabled");
endmodule

/* File: vsp_top_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module vsp_top_tb;
  import vsp_pkg::*;
  localparam int NCYC = 200;
  localparam int PCYC = 300;
  logic        clk, rst, bus_wr, bus_rd, cmd_test, cmd_en, cmd_lock, cmd_sync_n, cmd_tie;
  logic [3:0]  bus_addr;
  logic [31:0] bus_wdata, bus_rdata, rd;
  logic [9:0]  cmd_data, par_data, rx_word;
  logic        pattern_gen_enable, sync_detect_enable_n, pll_locked, pair_bad;
  logic        lock_detect, self_check_pass, st, sc, irq;
  int          err_total, n_compared;

  vsp_top #(.NTSC_CYC(NCYC), .PAL_CYC(PCYC)) u_dut (
    .clk(clk), .rst(rst), .par_data(par_data), .pattern_gen_enable(pattern_gen_enable),
    .sync_detect_enable_n(sync_detect_enable_n), .pll_locked(pll_locked),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .lock_detect(lock_detect), .self_check_pass(self_check_pass),
    .serial_out_pair_true(st), .serial_out_pair_comp(sc), .irq(irq));

  vsp_src_model u_src (
    .clk(clk), .rst(rst), .cmd_data(cmd_data), .cmd_test(cmd_test), .cmd_en(cmd_en),
    .cmd_lock(cmd_lock), .cmd_sync_n(cmd_sync_n), .cmd_tie(cmd_tie), .lock_in(lock_detect),
    .serial_true(st), .serial_comp(sc), .par_data(par_data),
    .pattern_gen_enable(pattern_gen_enable), .sync_detect_enable_n(sync_detect_enable_n),
    .pll_locked(pll_locked), .rx_word(rx_word), .pair_bad(pair_bad));

  // Word rate of clk/10 stands in for the parallel clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim();
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
  endtask

  // Read data valid only in the cycle after the strobe
  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    @(posedge clk);
    d = bus_rdata;
  endtask

  task automatic seek_word(input logic [9:0] w, input string nm);
    for (int i = 0; i < 80 && rx_word !== w; i++) @(posedge clk);
    `CHK(nm, w, rx_word)
  endtask

  task automatic wait_lock(input logic v);
    for (int i = 0; i < 8 && lock_detect !== v; i++) @(posedge clk);
    `CHK("lock_detect", v, lock_detect)
  endtask

  task automatic wait_pass(input logic v, input int lim, output int t);
    for (t = 0; t < lim && self_check_pass !== v; t++) @(posedge clk);
    `CHK("self_check_pass", v, self_check_pass)
  endtask

  task automatic t_reset();
    `CHK("comp_in_reset", 1'b1, sc)
    `CHK("pass_in_reset", 1'b0, self_check_pass)
    bus_read(REG_CTRL, rd);
    `CHK("ctrl_reset", {30'h0, CTRL_RESET}, rd)
    bus_read(REG_IRQ_MASK, rd);
    `CHK("mask_reset", {28'h0, MASK_RESET}, rd)
    bus_read(4'h2, rd);
    `CHK("unmapped", 32'h0, rd)
  endtask

  task automatic t_lock_irq();
    cmd_lock <= 1'b1;
    wait_lock(1'b1);
    bus_read(REG_IRQ_STAT, rd);
    `CHK("lock_event", 1'b1, rd[IRQ_LOCK])
    `CHK("irq_masked", 1'b0, irq)
    bus_write(REG_IRQ_MASK, 32'h1 << IRQ_LOCK);
    tick(3);
    `CHK("irq_unmasked", 1'b1, irq)
    bus_write(REG_IRQ_STAT, 32'h1 << IRQ_LOCK);
    tick(3);
    `CHK("irq_cleared", 1'b0, irq)
    bus_write(REG_IRQ_MASK, 32'h0);
  endtask

  // Clipped ones word then two clipped zeros words, held over several word ticks
  task automatic trs_burst();
    cmd_data <= 10'h3FE;
    tick(30);
    cmd_data <= 10'h001;
    tick(30);
  endtask

  task automatic t_normal();
    cmd_test <= 1'b0;
    cmd_data <= 10'h2A5;
    tick(5);
    seek_word(10'h2A5, "normal_word");
    bus_read(REG_STATUS, rd);
    `CHK("active_low_en", 1'b0, rd[2])
    cmd_sync_n <= 1'b1;
    tick(5);
    bus_read(REG_STATUS, rd);
    `CHK("sync_off", 1'b1, rd[1])
    trs_burst();
    bus_read(REG_IRQ_STAT, rd);
    `CHK("trs_when_off", 1'b0, rd[IRQ_TRS])
    cmd_sync_n <= 1'b0;
    tick(5);
    bus_read(REG_STATUS, rd);
    `CHK("sync_on", 1'b0, rd[1])
    trs_burst();
    bus_read(REG_IRQ_STAT, rd);
    `CHK("trs_when_on", 1'b1, rd[IRQ_TRS])
    bus_write(REG_IRQ_STAT, 32'hF);
  endtask

  task automatic t_codes();
    int t;
    for (int c = 0; c < 16; c++) begin
      cmd_test <= 1'b1;
      cmd_data <= {6'h00, 4'(c)};
      tick(4);
      cmd_en <= 1'b1;
      tick(8);
      bus_read(REG_STATUS, rd);
      `CHK("latched_code", 4'(c), rd[11:8])
      `CHK("pattern_active", 1'b1, rd[2])
      `CHK("self_running", (c == 3 || c == 5), rd[3])
      if (c == 0) begin
        seek_word(BLACK_Y, "black_luma");
        seek_word(BLACK_C, "black_chroma");
        // A plain pattern must never report a pass
        for (t = 0; t < NCYC + 20 && self_check_pass !== 1'b1; t++) @(posedge clk);
        `CHK("no_pass_plain", 1'b0, self_check_pass)
      end
      if (c == 1) begin
        seek_word(PLL_Y, "pll_luma");
      end
      if (c == 2) begin
        seek_word(EQ_Y, "eq_luma");
      end
      cmd_en <= 1'b0;
      tick(8);
      bus_read(REG_STATUS, rd);
      `CHK("pattern_ended", 1'b0, rd[2])
    end
  endtask

  task automatic t_self(input logic [3:0] code, input int cyc);
    int t;
    cmd_test <= 1'b1;
    cmd_data <= {6'h00, code};
    tick(4);
    cmd_en <= 1'b1;
    @(posedge clk);
    wait_pass(1'b1, cyc + 40, t);
    `CHK("pass_not_early", 1'b1, t >= cyc - 5)
    bus_read(REG_IRQ_STAT, rd);
    `CHK("pass_event", 1'b1, rd[IRQ_PASS])
    `CHK("no_error", 1'b0, rd[IRQ_FAIL])
    bus_write(REG_IRQ_STAT, 32'hF);
    cmd_en <= 1'b0;
    wait_pass(1'b0, 8, t);
  endtask

  task automatic t_tie();
    int t;
    cmd_lock <= 1'b0;
    wait_lock(1'b0);
    cmd_tie  <= 1'b1;
    cmd_test <= 1'b1;
    cmd_data <= {6'h00, CODE_NTSC_BARS};
    tick(4);
    cmd_lock <= 1'b1;
    wait_pass(1'b1, NCYC + 50, t);
    cmd_tie <= 1'b0;
    wait_pass(1'b0, 12, t);
  endtask

  initial begin
    rst = 1'b1; bus_wr = 1'b0; bus_rd = 1'b0; bus_addr = 4'h0; bus_wdata = 32'h0;
    cmd_data = 10'h000; cmd_test = 1'b0; cmd_en = 1'b0; cmd_lock = 1'b0;
    cmd_sync_n = 1'b0; cmd_tie = 1'b0; err_total = 0; n_compared = 0;
    tick(5);
    rst <= 1'b0;
    tick(1);
    t_reset();
    t_lock_irq();
    t_normal();
    t_codes();
    t_self(CODE_NTSC_BARS, NCYC);
    t_self(CODE_PAL_PLL, PCYC);
    t_tie();
    `CHK("pair_complement", 1'b0, pair_bad)
    end_sim();
  end

  // Hang guard
  initial begin
    tick(100000);
    err_total++;
    end_sim();
  end
endmodule
